// ---- uvs_i2c_port.v ----
// Slave-side register access port for the two-wire serial bus
// Behaviour
// - Own address with write bit opens write
// - First byte after address selects register
// - Data byte latched only once complete
// - Address steps up after each written byte
// - Selected register kept for later read
// - Works with serial clock up to 400 kHz
// - Repeated start with read returns selected data
// - Continued reads step address and return next
`timescale 1ns/1ps
`include "uvs_i2c_map.vh"
module uvs_i2c_port
#(
  parameter DEV_ADDR = `UVS_DEV_ADDR
)
(
  clk,
  nrst,
  sclIn,
  sdaIn,
  sdaOut,
  sdaOe,
  regSel,
  wrData,
  wrStb,
  rdData,
  rdStb,
  busActive
);
  input wire clk;
  input wire nrst;
  input wire sclIn;
  input wire sdaIn;
  output reg sdaOut;
  output reg sdaOe;
  output reg [7:0] regSel;
  output reg [7:0] wrData;
  output reg wrStb;
  input wire [7:0] rdData;
  output reg rdStb;
  output reg busActive;

  localparam ST_IDLE = 3'h0;
  localparam ST_DEVADR = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_REGADR = 3'h3;
  localparam ST_WDATA = 3'h4;
  localparam ST_RDATA = 3'h5;
  localparam ST_RACK = 3'h6;

  wire sclRise;
  wire sclFall;
  wire startSeen;
  wire stopSeen;
  wire sdaLevel;

  reg [2:0] state_ff;
  reg [2:0] afterAck_ff;
  reg [2:0] bitCnt_ff;
  reg [7:0] shift_ff;
  reg [7:0] txShift_ff;
  reg regPhase_ff;
  reg ackDone_ff;

  // Sampler runs on clk; the 20 MHz clock gives about 50 samples per 400 kHz bit
  uvs_line_sampler uSampler
  (
    .clk(clk),
    .nrst(nrst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen),
    .sdaLevel(sdaLevel)
  );

  // Transfer sequencer: address, register select, data bytes, acknowledges
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      state_ff <= ST_IDLE;
      afterAck_ff <= ST_IDLE;
      bitCnt_ff <= `UVS_BIT_CNT_RESET;
      shift_ff <= 8'h00;
      txShift_ff <= 8'h00;
      regPhase_ff <= 1'b0;
      ackDone_ff <= 1'b0;
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      regSel <= `UVS_ADDR_RESET;
      wrData <= 8'h00;
      wrStb <= 1'b0;
      rdStb <= 1'b0;
      busActive <= 1'b0;
    end
    else
    begin
      wrStb <= 1'b0;
      rdStb <= 1'b0;
      sdaOut <= 1'b0;
      if (stopSeen)
      begin
        state_ff <= ST_IDLE;
        sdaOe <= 1'b0;
        busActive <= 1'b0;
      end
      else if (startSeen)
      begin
        // Start or repeated start; register selection is kept
        state_ff <= ST_DEVADR;
        bitCnt_ff <= `UVS_BIT_CNT_RESET;
        sdaOe <= 1'b0;
        busActive <= 1'b1;
      end
      else
      begin
        case (state_ff)
          ST_IDLE:
          begin
            sdaOe <= 1'b0;
          end
          ST_DEVADR, ST_REGADR, ST_WDATA:
          begin
            if (sclRise)
            begin
              shift_ff <= {shift_ff[6:0], sdaLevel};
              bitCnt_ff <= bitCnt_ff + 3'h1;
            end
            else if (sclFall && bitCnt_ff == 3'h0 && regPhase_ff)
            begin
              regPhase_ff <= 1'b0;
              ackDone_ff <= 1'b0;
              if (state_ff == ST_DEVADR)
              begin
                if (shift_ff[7:1] != DEV_ADDR[6:0])
                begin
                  state_ff <= ST_IDLE;
                end
                else if (shift_ff[0])
                begin
                  // Read address: selected register goes out after ack
                  state_ff <= ST_ACK;
                  afterAck_ff <= ST_RDATA;
                  txShift_ff <= rdData;
                  rdStb <= 1'b1;
                  sdaOe <= 1'b1;
                end
                else
                begin
                  state_ff <= ST_ACK;
                  afterAck_ff <= ST_REGADR;
                  sdaOe <= 1'b1;
                end
              end
              else if (state_ff == ST_REGADR)
              begin
                regSel <= shift_ff;
                state_ff <= ST_ACK;
                afterAck_ff <= ST_WDATA;
                sdaOe <= 1'b1;
              end
              else
              begin
                // Whole byte in hand: write it to the selected register
                wrData <= shift_ff;
                wrStb <= 1'b1;
                state_ff <= ST_ACK;
                afterAck_ff <= ST_WDATA;
                sdaOe <= 1'b1;
              end
            end
            if (sclRise && bitCnt_ff == 3'h7)
            begin
              regPhase_ff <= 1'b1;
            end
          end
          ST_ACK:
          begin
            // Hold SDA low through one clock high period
            sdaOe <= 1'b1;
            // Step the address once the strobe has carried the written index
            if (wrStb)
            begin
              regSel <= regSel + 8'h01;
            end
            if (sclRise)
            begin
              ackDone_ff <= 1'b1;
            end
            else if (sclFall && ackDone_ff)
            begin
              state_ff <= afterAck_ff;
              bitCnt_ff <= `UVS_BIT_CNT_RESET;
              if (afterAck_ff == ST_RDATA)
              begin
                sdaOe <= ~txShift_ff[7];
                txShift_ff <= {txShift_ff[6:0], 1'b0};
              end
              else
              begin
                sdaOe <= 1'b0;
              end
            end
          end
          ST_RDATA:
          begin
            // Shift out MSB first; drive low only for zero bits
            if (sclFall)
            begin
              bitCnt_ff <= bitCnt_ff + 3'h1;
              if (bitCnt_ff == 3'h7)
              begin
                sdaOe <= 1'b0;
                // Next index now, so rdData is settled before the host ack ends
                regSel <= regSel + 8'h01;
                state_ff <= ST_RACK;
                ackDone_ff <= 1'b0;
              end
              else
              begin
                sdaOe <= ~txShift_ff[7];
                txShift_ff <= {txShift_ff[6:0], 1'b0};
              end
            end
          end
          ST_RACK:
          begin
            sdaOe <= 1'b0;
            if (sclRise)
            begin
              ackDone_ff <= ~sdaLevel;
            end
            else if (sclFall)
            begin
              if (ackDone_ff)
              begin
                // Host acknowledged: next register goes out
                txShift_ff <= {rdData[6:0], 1'b0};
                sdaOe <= ~rdData[7];
                rdStb <= 1'b1;
                bitCnt_ff <= `UVS_BIT_CNT_RESET;
                state_ff <= ST_RDATA;
              end
              else
              begin
                state_ff <= ST_IDLE;
              end
            end
          end
          default:
          begin
            state_ff <= ST_IDLE;
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule // uvs_i2c_port

// ---- uvs_i2c_map.vh ----
// Constants for the two-wire register access port
`ifndef UVS_I2C_MAP_VH
`define UVS_I2C_MAP_VH
`define UVS_DEV_ADDR 7'h0d
`define UVS_ADDR_RESET 8'h00
`define UVS_BIT_CNT_RESET 3'h0
`define UVS_CLK_MHZ 20
`define UVS_SCL_MAX_KHZ 400
`define UVS_SCL_MIN_CYC ((`UVS_CLK_MHZ * 1000) / `UVS_SCL_MAX_KHZ)
`endif

// ---- uvs_line_sampler.v ----
// Edge and condition detector for the serial clock and data lines
`timescale 1ns/1ps
module uvs_line_sampler
(
  clk,
  nrst,
  sclIn,
  sdaIn,
  sclRise,
  sclFall,
  startSeen,
  stopSeen,
  sdaLevel
);
  input wire clk;
  input wire nrst;
  input wire sclIn;
  input wire sdaIn;
  output wire sclRise;
  output wire sclFall;
  output wire startSeen;
  output wire stopSeen;
  output wire sdaLevel;

  reg sclA_ff;
  reg sdaA_ff;
  reg sclB_ff;
  reg sdaB_ff;

  // Two-stage history of each line; bus idles high
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      sclA_ff <= 1'b1;
      sdaA_ff <= 1'b1;
      sclB_ff <= 1'b1;
      sdaB_ff <= 1'b1;
    end
    else
    begin
      sclA_ff <= sclIn;
      sdaA_ff <= sdaIn;
      sclB_ff <= sclA_ff;
      sdaB_ff <= sdaA_ff;
    end
  end

  // Edges and bus conditions from the registered history
  assign sclRise = sclA_ff & ~sclB_ff;
  assign sclFall = ~sclA_ff & sclB_ff;
  assign startSeen = sclA_ff & sclB_ff & ~sdaA_ff & sdaB_ff;
  assign stopSeen = sclA_ff & sclB_ff & sdaA_ff & ~sdaB_ff;
  assign sdaLevel = sdaA_ff;
endmodule // uvs_line_sampler

// ---- uvs_i2c_port_chk.sv ----
// Checker for the two-wire register access port
`timescale 1ns/1ps
module uvs_i2c_port_chk
(
  input logic clk,
  input logic nrst,
  input logic sclIn,
  input logic sdaIn,
  input logic sdaOut,
  input logic sdaOe,
  input logic [7:0] regSel,
  input logic [7:0] wrData,
  input logic wrStb,
  input logic [7:0] rdData,
  input logic rdStb,
  input logic busActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Bus line rules on the device side
  sda_zero_a: assert property (sdaOut == 1'b0) else $error("data value not low");
  wr_pulse_a: assert property (wrStb |=> !wrStb) else $error("write strobe too long");
  wr_frame_a: assert property (wrStb |-> busActive && !sclIn) else $error("write outside byte end");
  rd_pulse_a: assert property (rdStb |=> !rdStb) else $error("read strobe too long");
  sda_hold_a: assert property (sclIn [*4] |-> $stable(sdaOe)) else $error("data moved while clock high");
  idle_quiet_a: assert property (!busActive |-> !sdaOe) else $error("drive while idle");
  start_only_a: assert property ($rose(busActive) |-> sclIn && $past(sclIn, 3)) else $error("bad start");
  sel_frame_a: assert property ($changed(regSel) |-> $past(busActive)) else $error("select moved idle");
  strobe_excl_a: assert property (!(wrStb && rdStb)) else $error("both strobes");
  // Main scenarios
  wr_c: cover property (wrStb);
  rd_c: cover property (rdStb);
  ack_c: cover property ($rose(sdaOe));
endmodule // uvs_i2c_port_chk
bind uvs_i2c_port uvs_i2c_port_chk chk (.clk(clk), .nrst(nrst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .regSel(regSel), .wrData(wrData), .wrStb(wrStb), .rdData(rdData), .rdStb(rdStb),
  .busActive(busActive));

// ---- uvs_host.sv ----
// Bus host model driving the serial clock and data lines
`timescale 1ns/1ps
module uvs_host
(
  input logic clk,
  input logic sda,
  output logic scl,
  output logic sdaHost
);
  // Idle bus with both lines released high
  initial
  begin
    scl = 1'b1;
    sdaHost = 1'b1;
  end
  task hw; input integer n; repeat (n) @(negedge clk); endtask
  // Start or repeated start; 30 cycles per half keeps the clock near 333 kHz
  task start;
  begin
    sdaHost = 1'b1; hw(30); scl = 1'b1; hw(30); sdaHost = 1'b0; hw(30); scl = 1'b0;
  end
  endtask
  task stop;
  begin
    sdaHost = 1'b0; hw(30); scl = 1'b1; hw(30); sdaHost = 1'b1; hw(30);
  end
  endtask
  // One clock pulse, driving d and sampling the line mid high
  task bitx; input logic d; output logic q;
  begin
    sdaHost = d; hw(30); scl = 1'b1; hw(15); q = sda; hw(15); scl = 1'b0;
  end
  endtask
  // Byte out MSB first, then release for the device acknowledge
  task wbyte; input logic [7:0] b; output logic ack; integer i; logic q;
  begin
    for (i = 7; i >= 0; i = i - 1) bitx(b[i], q);
    bitx(1'b1, q); ack = !q;
  end
  endtask
  // Byte in MSB first, then acknowledge unless it is the last
  task rbyte; input logic ackIt; output logic [7:0] b; integer i; logic q;
  begin
    for (i = 7; i >= 0; i = i - 1) begin bitx(1'b1, q); b[i] = q; end
    bitx(!ackIt, q);
  end
  endtask
endmodule // uvs_host

// ---- testbench.sv ----
// Testbench for the two-wire register access port
`timescale 1ns/1ps
module testbench;
  reg clk, nrst;
  wire sclIn, hostSda, sdaOut, sdaOe, wrStb, rdStb, busActive;
  wire [7:0] regSel, wrData;
  reg [7:0] regs [0:255];
  integer miscompares, checks, wrCount, rdCount, cycles, i;
  logic ack;
  logic [7:0] b;
  wire sdaIn = hostSda & ~sdaOe;
  wire [7:0] rdData = regs[regSel];
  uvs_i2c_port dut (.clk(clk), .nrst(nrst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .regSel(regSel), .wrData(wrData), .wrStb(wrStb), .rdData(rdData), .rdStb(rdStb), .busActive(busActive));
  uvs_host host (.clk(clk), .sda(sdaIn), .scl(sclIn), .sdaHost(hostSda));
  always #25 clk = ~clk;
  // Register file behind the port; a strobe writes the register selected with it
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (wrStb) begin regs[regSel] <= wrData; wrCount <= wrCount + 1; end
    if (rdStb) rdCount <= rdCount + 1;
    if (cycles == 40000) begin miscompares = miscompares + 1; end_of_test; end
  end
  task chk; input logic [7:0] got; input logic [7:0] exp;
  begin
    checks = checks + 1;
    if (got !== exp) begin miscompares = miscompares + 1; $display("ERROR %0t: got %h want %h", $time, got, exp); end
  end
  endtask
  task end_of_test;
  begin
    $display("miscompares=%0d checks=%0d", miscompares, checks);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  end
  endtask
  // Burst write of two bytes from register 10h
  task t_write;
  begin
    host.start; host.wbyte(8'h1a, ack); chk(ack, 8'h01);
    host.wbyte(8'h10, ack); chk(ack, 8'h01);
    host.wbyte(8'ha5, ack); chk(ack, 8'h01);
    host.wbyte(8'h3c, ack); chk(ack, 8'h01); host.stop;
    chk(regs[8'h10], 8'ha5);
    chk(regs[8'h11], 8'h3c);
    chk(wrCount[7:0], 8'h02);
  end
  endtask
  // Select then repeated start and read two bytes
  task t_read;
  begin
    host.start; host.wbyte(8'h1a, ack); chk(ack, 8'h01);
    host.wbyte(8'h20, ack); chk(ack, 8'h01);
    host.start; host.wbyte(8'h1b, ack); chk(ack, 8'h01);
    host.rbyte(1'b1, b); chk(b, 8'h5e);
    host.rbyte(1'b0, b); chk(b, 8'hc3);
    host.stop;
    chk(rdCount[7:0], 8'h02);
  end
  endtask
  // Another bus address is neither acknowledged nor written
  task t_other;
  begin
    host.start; host.wbyte(8'h1c, ack); chk(ack, 8'h00);
    host.wbyte(8'h10, ack); host.wbyte(8'h77, ack); host.stop;
    chk(regs[8'h10], 8'ha5);
    chk(wrCount[7:0], 8'h02);
    chk(busActive, 8'h00);
  end
  endtask
  // Main sequence
  initial
  begin
    clk = 1'b0; nrst = 1'b0;
    miscompares = 0; checks = 0; wrCount = 0; rdCount = 0; cycles = 0;
    for (i = 0; i < 256; i = i + 1) regs[i] = 8'h00;
    regs[8'h20] = 8'h5e; regs[8'h21] = 8'hc3;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_write;
    t_read;
    t_other;
    end_of_test;
  end
endmodule // testbench
